/* File: wmc_map.vh */
// Purpose: Register indices, field positions and reset values
// Assumes: Byte address of a register is four times its index
// Notes: Definitions only
`ifndef WMC_MAP_VH
`define WMC_MAP_VH

// Register indices
`define WMC_IDX_AMP_AVG 6'h34
`define WMC_IDX_AMP_RES 6'h35
`define WMC_IDX_PH_CFG 6'h36
`define WMC_IDX_PH_REF 6'h37
`define WMC_IDX_PH_AVG 6'h38
`define WMC_IDX_PH_RES 6'h39
`define WMC_IDX_CAP_CFG 6'h3a
`define WMC_IDX_CAP_REF 6'h3b
`define WMC_IDX_CAP_AVG 6'h3c
`define WMC_IDX_CAP_RES 6'h3d
`define WMC_IDX_IRQ_STAT 6'h20
`define WMC_IDX_IRQ_MASK 6'h21
`define WMC_IDX_CMD 6'h22
`define WMC_IDX_WAKE_EN 6'h23

// Configuration fields
`define WMC_THR_MSB 7
`define WMC_THR_LSB 4
`define WMC_INCL_BIT 3
`define WMC_WT_MSB 2
`define WMC_WT_LSB 1
`define WMC_USE_AVG_BIT 0

// Command bits
`define WMC_CMD_SET_DEFAULT 0

// Averaging shift for weight code 00
`define WMC_WT_BASE_SHIFT 3'h2

// Reset values
`define WMC_RST_BYTE 8'h00
`define WMC_RST_CH3 3'h0

`endif

/* File: wmc_wakeup_compare.v */
// Purpose: Wake-up measurement compare, auto-average and result displays
// Assumes: APB slave, one clock, measurement results arrive as pulses
// Notes: Channel 0 amplitude, 1 phase, 2 capacitance
`include "wmc_map.vh"

module wmc_wakeup_compare
(
   // Clock, reset, enable
   input wire clk_i,
   input wire reset_n_i,
   input wire ce_i,
   // APB slave
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [7:0] paddr_i,
   input wire [31:0] pwdata_i,
   output wire [31:0] prdata_o,
   output wire pready_o,
   output wire pslverr_o,
   // Amplitude settings held outside
   input wire [7:0] amp_cfg_i,
   input wire [7:0] amp_ref_i,
   // Wake-up timer and measurement front end
   input wire wake_timeout_i,
   input wire [2:0] meas_valid_i,
   input wire [7:0] meas_data_i,
   output wire [2:0] meas_request_o,
   // Interrupt
   output wire irq_o
);

   // Average step: old plus difference over weight
   function [7:0] wmc_avg;
      input [7:0] avg;
      input [7:0] res;
      input [1:0] wsel;
      reg signed [9:0] d;
      reg signed [9:0] s;
      reg [2:0] sh;
      begin
         d = $signed({2'b00, res}) - $signed({2'b00, avg});
         sh = {1'b0, wsel} + `WMC_WT_BASE_SHIFT;
         s = d >>> sh;
         wmc_avg = avg + s[7:0];
      end
   endfunction

   // Unsigned distance between result and reference
   function [7:0] wmc_abs_diff;
      input [7:0] a;
      input [7:0] b;
      begin
         if (a >= b)
         begin
            wmc_abs_diff = a - b;
         end
         else
         begin
            wmc_abs_diff = b - a;
         end
      end
   endfunction

   reg [31:0] prdata_q;
   reg pready_q;
   reg pslverr_q;
   reg [7:0] ph_cfg_q;
   reg [7:0] ph_ref_q;
   reg [7:0] cap_cfg_q;
   reg [7:0] cap_ref_q;
   reg [2:0] stat_q;
   reg [2:0] stat_d;
   reg [2:0] mask_q;
   reg [2:0] mask_d;
   reg [2:0] wake_en_q;
   reg [2:0] req_q;
   reg irq_q;
   reg [31:0] rdata_d;
   reg hit_d;

   wire [5:0] idx;
   wire setup;
   wire wr;
   wire set_default;
   wire wr_stat;
   wire wr_mask;
   wire [23:0] cfg_all;
   wire [23:0] ref_all;
   wire [23:0] avg_all;
   wire [23:0] raw_all;
   wire [2:0] trig;

   assign idx = paddr_i[7:2];
   assign setup = psel_i & ~penable_i;
   assign wr = psel_i & penable_i & pready_q & pwrite_i & ~pslverr_q;
   assign set_default = wr & (idx == `WMC_IDX_CMD) & pwdata_i[`WMC_CMD_SET_DEFAULT];
   assign wr_stat = wr & (idx == `WMC_IDX_IRQ_STAT);
   assign wr_mask = wr & (idx == `WMC_IDX_IRQ_MASK);
   assign cfg_all = {cap_cfg_q, ph_cfg_q, amp_cfg_i};
   assign ref_all = {cap_ref_q, ph_ref_q, amp_ref_i};

   // Per-channel compare and averaging
   genvar k;
   generate
      for (k = 0; k < 3; k = k + 1)
      begin : g_ch
         reg [7:0] avg_q;
         reg [7:0] raw_q;
         wire [7:0] cfg;
         wire [7:0] rf;
         wire [7:0] diff;
         wire over;

         assign cfg = cfg_all[k*8 +: 8];
         assign rf = cfg[`WMC_USE_AVG_BIT] ? avg_q : ref_all[k*8 +: 8];
         assign diff = wmc_abs_diff(meas_data_i, rf);
         assign over = diff > {4'h0, cfg[`WMC_THR_MSB:`WMC_THR_LSB]};
         assign trig[k] = meas_valid_i[k] & over;
         assign avg_all[k*8 +: 8] = avg_q;
         assign raw_all[k*8 +: 8] = raw_q;

         always @(posedge clk_i or negedge reset_n_i)
         begin
            if (!reset_n_i)
            begin
               avg_q <= `WMC_RST_BYTE;
               raw_q <= `WMC_RST_BYTE;
            end
            else if (ce_i)
            begin
               if (set_default)
               begin
                  avg_q <= `WMC_RST_BYTE;
                  raw_q <= `WMC_RST_BYTE;
               end
               else if (meas_valid_i[k])
               begin
                  raw_q <= meas_data_i;
                  if (!over || cfg[`WMC_INCL_BIT])
                  begin
                     avg_q <= wmc_avg(avg_q, meas_data_i, cfg[`WMC_WT_MSB:`WMC_WT_LSB]);
                  end
               end
            end
         end
      end
   endgenerate

   // Read mux and address check
   always @*
   begin
      rdata_d = 32'h0000_0000;
      hit_d = (paddr_i[1:0] == 2'b00);
      case (idx)
         `WMC_IDX_AMP_AVG: rdata_d[7:0] = avg_all[7:0];
         `WMC_IDX_AMP_RES: rdata_d[7:0] = raw_all[7:0];
         `WMC_IDX_PH_CFG: rdata_d[7:0] = ph_cfg_q;
         `WMC_IDX_PH_REF: rdata_d[7:0] = ph_ref_q;
         `WMC_IDX_PH_AVG: rdata_d[7:0] = avg_all[15:8];
         `WMC_IDX_PH_RES: rdata_d[7:0] = raw_all[15:8];
         `WMC_IDX_CAP_CFG: rdata_d[7:0] = cap_cfg_q;
         `WMC_IDX_CAP_REF: rdata_d[7:0] = cap_ref_q;
         `WMC_IDX_CAP_AVG: rdata_d[7:0] = avg_all[23:16];
         `WMC_IDX_CAP_RES: rdata_d[7:0] = raw_all[23:16];
         `WMC_IDX_IRQ_STAT: rdata_d[2:0] = stat_q;
         `WMC_IDX_IRQ_MASK: rdata_d[2:0] = mask_q;
         `WMC_IDX_CMD: rdata_d[2:0] = 3'h0;
         `WMC_IDX_WAKE_EN: rdata_d[2:0] = wake_en_q;
         default: hit_d = 1'b0;
      endcase
      if (!hit_d)
      begin
         rdata_d = 32'h0000_0000;
      end
   end

   // Zero-wait answer prepared in the setup cycle
   always @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end
      else if (ce_i)
      begin
         if (setup)
         begin
            prdata_q <= pwrite_i ? 32'h0000_0000 : rdata_d;
            pready_q <= 1'b1;
            pslverr_q <= ~hit_d;
         end
         else
         begin
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
         end
      end
   end

   // Writable configuration
   always @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         ph_cfg_q <= `WMC_RST_BYTE;
         ph_ref_q <= `WMC_RST_BYTE;
         cap_cfg_q <= `WMC_RST_BYTE;
         cap_ref_q <= `WMC_RST_BYTE;
         wake_en_q <= `WMC_RST_CH3;
      end
      else if (ce_i)
      begin
         if (set_default)
         begin
            ph_cfg_q <= `WMC_RST_BYTE;
            ph_ref_q <= `WMC_RST_BYTE;
            cap_cfg_q <= `WMC_RST_BYTE;
            cap_ref_q <= `WMC_RST_BYTE;
            wake_en_q <= `WMC_RST_CH3;
         end
         else if (wr)
         begin
            case (idx)
               `WMC_IDX_PH_CFG: ph_cfg_q <= pwdata_i[7:0];
               `WMC_IDX_PH_REF: ph_ref_q <= pwdata_i[7:0];
               `WMC_IDX_CAP_CFG: cap_cfg_q <= pwdata_i[7:0];
               `WMC_IDX_CAP_REF: cap_ref_q <= pwdata_i[7:0];
               `WMC_IDX_WAKE_EN: wake_en_q <= pwdata_i[2:0];
               default: ph_cfg_q <= ph_cfg_q;
            endcase
         end
      end
   end

   // Sticky status: a new event beats a same-cycle clear
   always @*
   begin
      stat_d = stat_q;
      if (set_default)
      begin
         stat_d = `WMC_RST_CH3;
      end
      else if (wr_stat)
      begin
         stat_d = stat_q & ~pwdata_i[2:0];
      end
      stat_d = stat_d | trig;
   end

   // Mask next value, so irq follows a mask write at once
   always @*
   begin
      mask_d = mask_q;
      if (set_default)
      begin
         mask_d = `WMC_RST_CH3;
      end
      else if (wr_mask)
      begin
         mask_d = pwdata_i[2:0];
      end
   end

   // Status, interrupt and measurement requests
   always @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         stat_q <= `WMC_RST_CH3;
         mask_q <= `WMC_RST_CH3;
         irq_q <= 1'b0;
         req_q <= `WMC_RST_CH3;
      end
      else if (ce_i)
      begin
         stat_q <= stat_d;
         mask_q <= mask_d;
         irq_q <= |(stat_d & mask_d);
         req_q <= wake_timeout_i ? wake_en_q : 3'h0;
      end
   end

   assign prdata_o = prdata_q;
   assign pready_o = pready_q;
   assign pslverr_o = pslverr_q;
   assign meas_request_o = req_q;
   assign irq_o = irq_q;

endmodule

/* File: wmc_wakeup_compare_sva.sv */
// Purpose: Port assertions for the wake-up compare block
// Assumes: One clock, async active-low reset
// Notes: Bound to the block below
module wmc_chk
(
   // Clock and control
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic ce_i,
   // Register bus
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   // Measurement side
   input wire logic [7:0] amp_cfg_i,
   input wire logic [7:0] amp_ref_i,
   input wire logic wake_timeout_i,
   input wire logic [2:0] meas_valid_i,
   input wire logic [7:0] meas_data_i,
   input wire logic [2:0] meas_request_o,
   input wire logic irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   sequence s_setup;
      psel_i && !penable_i && ce_i ##1 ce_i;
   endsequence
   sequence s_access;
      pready_o ##1 !pready_o;
   endsequence
   a_setup_answer: assert property (s_setup |-> s_access) else $error("no single answer");
   a_err_ready: assert property (pslverr_o |-> pready_o) else $error("error without ready");
   a_idle_zero: assert property (!pready_o |-> prdata_o == 32'h0) else $error("idle data");
   a_byte_wide: assert property (pready_o |-> prdata_o[31:8] == 24'h0) else $error("upper bits");
   a_req_after_to: assert property (|meas_request_o |-> $past(wake_timeout_i) || !$past(ce_i))
      else $error("request without timeout");
   a_req_pulse: assert property (|meas_request_o && !wake_timeout_i && ce_i |=> meas_request_o == 3'h0)
      else $error("request too long");
   a_irq_cause: assert property ($rose(irq_o) |-> |$past(meas_valid_i) || $past(psel_i) && $past(pwrite_i))
      else $error("irq without event");
   a_irq_sticky: assert property (irq_o && !(psel_i && pwrite_i) |=> irq_o) else $error("irq dropped");
endmodule

bind wmc_wakeup_compare wmc_chk chk_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
   .pready_o(pready_o), .pslverr_o(pslverr_o), .amp_cfg_i(amp_cfg_i), .amp_ref_i(amp_ref_i),
   .wake_timeout_i(wake_timeout_i), .meas_valid_i(meas_valid_i), .meas_data_i(meas_data_i),
   .meas_request_o(meas_request_o), .irq_o(irq_o));

/* File: wmc_wakeup_compare_bench.sv */
// Purpose: Self-checking bench for the wake-up compare block
// Assumes: Zero-wait APB answers, results as one-cycle pulses
// Notes: Each scenario checks its own outcome
`include "wmc_map.vh"
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin mismatches++; \
   $display("mismatch %s expected %h seen %h", n, e, s); end end
module wmc_wakeup_compare_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 0, reset_n_i = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, wto = 0, re;
   logic [7:0] paddr = 8'h00, md = 8'h00, amp_cfg = 8'h00, amp_ref = 8'h00;
   logic [31:0] pwdata = 32'h0, rv, prdata_o;
   logic [2:0] mv = 3'h0, meas_request_o;
   logic pready_o, pslverr_o, irq_o;
   int mismatches = 0, samples_checked = 0;
   wmc_wakeup_compare dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .amp_cfg_i(amp_cfg), .amp_ref_i(amp_ref),
      .wake_timeout_i(wto), .meas_valid_i(mv), .meas_data_i(md), .meas_request_o(meas_request_o),
      .irq_o(irq_o));
   initial forever #2 clk_i = ~clk_i;
   task apb(input logic w, input logic [5:0] i, input logic [7:0] d);
      @(posedge clk_i);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= {i, 2'b00}; pwdata <= {24'h0, d};
      @(posedge clk_i);
      penable <= 1;
      do @(posedge clk_i); while (pready_o !== 1'b1);
      rv = prdata_o; re = pslverr_o;
      psel <= 0; penable <= 0;
   endtask
   task meas(input logic [2:0] c, input logic [7:0] d);
      @(posedge clk_i);
      mv <= c; md <= d;
      @(posedge clk_i);
      mv <= 3'h0;
      #1;
   endtask
   task t_defaults;
      for (int i = 6'h34; i <= 6'h3d; i++)
      begin
         apb(0, i[5:0], 8'h00);
         `CHK("default", 32'h0, rv)
      end
   endtask
   task t_amp;
      amp_cfg <= 8'h08;
      meas(3'h1, 8'h40);
      apb(0, `WMC_IDX_AMP_RES, 8'h00); `CHK("amp raw", 32'h40, rv)
      apb(0, `WMC_IDX_AMP_AVG, 8'h00); `CHK("amp avg", 32'h10, rv)
   endtask
   task t_phase;
      apb(1, `WMC_IDX_IRQ_MASK, 8'h02); apb(1, `WMC_IDX_PH_REF, 8'h50); apb(1, `WMC_IDX_PH_CFG, 8'h20);
      meas(3'h2, 8'h53); `CHK("ph irq", 1'b1, irq_o)
      apb(0, `WMC_IDX_PH_AVG, 8'h00); `CHK("ph avg excl", 32'h0, rv)
      meas(3'h2, 8'h52);
      apb(0, `WMC_IDX_PH_AVG, 8'h00); `CHK("ph avg", 32'h14, rv)
      apb(0, `WMC_IDX_PH_RES, 8'h00); `CHK("ph raw", 32'h52, rv)
      apb(1, `WMC_IDX_IRQ_STAT, 8'h02); #1; `CHK("irq clr", 1'b0, irq_o)
      apb(0, `WMC_IDX_IRQ_STAT, 8'h00); `CHK("stat w1c", 32'h1, rv)
   endtask
   task t_avg_ref;
      apb(1, `WMC_IDX_CMD, 8'h01); apb(1, `WMC_IDX_IRQ_MASK, 8'h02);
      apb(1, `WMC_IDX_PH_REF, 8'h80); apb(1, `WMC_IDX_PH_CFG, 8'h11);
      meas(3'h2, 8'h01); `CHK("avg ref quiet", 1'b0, irq_o)
      meas(3'h2, 8'h03); `CHK("avg ref over", 1'b1, irq_o)
      apb(1, `WMC_IDX_IRQ_MASK, 8'h00); #1; `CHK("masked", 1'b0, irq_o)
      apb(1, `WMC_IDX_IRQ_MASK, 8'h02); #1; `CHK("unmasked", 1'b1, irq_o)
   endtask
   task t_weights;
      for (int w = 0; w < 4; w++)
      begin
         apb(1, `WMC_IDX_CMD, 8'h01); apb(1, `WMC_IDX_CAP_CFG, 8'hf8 | (w << 1));
         meas(3'h4, 8'h80);
         apb(0, `WMC_IDX_CAP_AVG, 8'h00); `CHK("cap avg", 32'h80 >> (w + 2), rv)
      end
      apb(1, `WMC_IDX_CAP_AVG, 8'h55);
      apb(0, `WMC_IDX_CAP_AVG, 8'h00); `CHK("ro write", 32'h04, rv)
      apb(1, `WMC_IDX_CMD, 8'h01);
      apb(0, `WMC_IDX_CAP_CFG, 8'h00); `CHK("cfg default", 32'h0, rv)
      apb(0, `WMC_IDX_CAP_RES, 8'h00); `CHK("raw default", 32'h0, rv)
      apb(0, 6'h00, 8'h00); `CHK("unmapped", 1'b1, re)
   endtask
   task t_timeout;
      apb(1, `WMC_IDX_WAKE_EN, 8'h05);
      @(posedge clk_i); wto <= 1;
      @(posedge clk_i); wto <= 0;
      #1; `CHK("request", 3'h5, meas_request_o)
      apb(1, `WMC_IDX_CMD, 8'h01);
      apb(0, `WMC_IDX_WAKE_EN, 8'h00); `CHK("wake default", 32'h0, rv)
   endtask
   task t_freeze;
      @(posedge clk_i); ce <= 0;
      meas(3'h2, 8'h33);
      @(posedge clk_i); ce <= 1;
      apb(0, `WMC_IDX_PH_RES, 8'h00); `CHK("frozen raw", 32'h0, rv)
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial
   begin
      #100us;
      mismatches++;
      stop_test;
   end
   initial
   begin
      repeat (10) @(posedge clk_i);
      reset_n_i <= 1;
      t_defaults; t_amp; t_phase; t_avg_ref; t_weights; t_freeze; t_timeout;
      stop_test;
   end
endmodule
